// [gpb_pkg.sv]
// Package for the port bank: register addresses, reset values, field positions, carriers.
// Notes on behaviour
// - Port 0 has four I/O pins, each with latch and own direction bit.
// - Ports 0, 2, 3, 4 pull-ups enable per bit, active in input mode.
// - Port 2 has four I/O pins that can also feed the converter.
// - Port 3 bits 0-3 are I/O with latch, direction and pull-up per bit.
// - Port 3 bit 4 is input only; as port input it loses reset function.
// - Shared pin role is taken after release; low pin before that holds reset.
// - Port 3 bits 0 and 1 also carry timer and interrupt alternates.
// - Port 4 has eight I/O pins with latch, direction and pull-up.
// - Port 4 bits 1-4 carry interrupt, serial and timer alternates.
// - Port 12 has four I/O pins with latch and per-bit direction.
// - Port 12 pull-ups exist on bits 0 and 3 only.
// - Internal oscillator selected: port 12 bits 1, 2 are plain port pins.
// - Crystal selected: port 12 bits 1, 2 belong to the oscillator.
// - External clock: bit 1 is clock input, bit 2 stays a port pin.
// - Oscillator pins of port 12 are pulled down during reset.
// - Reset puts every I/O port into input mode.
// - Port 13 is one output-only pin driven from its latch.
// - Port 13 drives low during reset.
// - Direction 0 turns the output buffer on, 1 turns it off.
// - Reads return pin level for inputs, latch value for outputs.
// - Port 2 mode bit 1 puts the pin in analog mode, not a port.
// - Reset loads all direction registers with all ones.
package gpb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register addresses
   localparam logic [15:0] ADDR_LATCH0  = 16'hFF00;
   localparam logic [15:0] ADDR_LATCH2  = 16'hFF02;
   localparam logic [15:0] ADDR_LATCH3  = 16'hFF03;
   localparam logic [15:0] ADDR_LATCH4  = 16'hFF04;
   localparam logic [15:0] ADDR_LATCH12 = 16'hFF0C;
   localparam logic [15:0] ADDR_LATCH13 = 16'hFF0D;
   localparam logic [15:0] ADDR_DIR0    = 16'hFF20;
   localparam logic [15:0] ADDR_DIR2    = 16'hFF22;
   localparam logic [15:0] ADDR_DIR3    = 16'hFF23;
   localparam logic [15:0] ADDR_DIR4    = 16'hFF24;
   localparam logic [15:0] ADDR_DIR12   = 16'hFF2C;
   localparam logic [15:0] ADDR_PU0     = 16'hFF30;
   localparam logic [15:0] ADDR_PU2     = 16'hFF32;
   localparam logic [15:0] ADDR_PU3     = 16'hFF33;
   localparam logic [15:0] ADDR_PU4     = 16'hFF34;
   localparam logic [15:0] ADDR_PULLUP_EN_PORT12    = 16'hFF3C;
   localparam logic [15:0] ADDR_ANALOG_SEL_PORT2    = 16'hFF84;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and fixed fields
   localparam logic [7:0] RST_DIR     = 8'hFF;
   localparam logic [7:0] RST_LATCH   = 8'h00;
   localparam logic [7:0] RST_CTRL    = 8'h00;
   localparam logic [3:0] DIR_UNUSED  = 4'hF;   // Upper nibble of 4-bit direction reads 1
   localparam logic [3:0] PULLUP_EN_PORT12_MASK   = 4'h9;   // Pull-ups only on bits 0 and 3
   localparam logic [3:0] OWN_XTAL    = 4'h6;   // Bits 1 and 2 to the oscillator
   localparam logic [3:0] OWN_EXTCLK  = 4'h2;   // Bit 1 to the clock input
   localparam logic [3:0] OWN_NONE    = 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions of alternate functions
   localparam int P3_TMR_A_BIT = 0;
   localparam int P3_TMR_B_BIT = 1;
   localparam int P4_IRQ3_BIT  = 1;
   localparam int P4_TMRB_BIT  = 2;
   localparam int P4_TX_BIT    = 3;
   localparam int P4_RX_BIT    = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {GPB_CLK_INT_OSC, GPB_CLK_XTAL, GPB_CLK_EXT} gpb_clk_sel_t;

   typedef struct packed {
      logic [3:0] p0;
      logic [3:0] p2;
      logic [3:0] p3;
      logic [7:0] p4;
      logic [3:0] p12;
   } gpb_pins_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        bit_op;
      logic [2:0]  bit_idx;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } gpb_cpu_req_t;

   typedef struct packed {
      logic       timer_capture_in_a;
      logic       timer_capture_in_b;
      logic [3:0] ext_irq_in;
      logic       serial_rx;
   } gpb_alt_in_t;

   localparam int SYNC_W = $bits(gpb_pins_t) + 1;

endpackage : gpb_pkg

// [gpb_sync.sv]
// Three-stage input synchroniser with agreement filter for all pin inputs.
`timescale 1ns/1ps
module gpb_sync (
   input  wire logic                      clk_sys,
   input  wire logic                      arst_n,
   input  wire logic [gpb_pkg::SYNC_W-1:0] async_in,
   output logic      [gpb_pkg::SYNC_W-1:0] sync_out
);
   typedef struct packed {
      logic [gpb_pkg::SYNC_W-1:0] s1;
      logic [gpb_pkg::SYNC_W-1:0] s2;
      logic [gpb_pkg::SYNC_W-1:0] s3;
      logic [gpb_pkg::SYNC_W-1:0] q;
   } gpb_sync_state_t;

   gpb_sync_state_t st;
   gpb_sync_state_t next_st;

   ////////////////////////////////////////////////////////////////////////////
   // Only stages two and three feed the filter; stage one is left alone
   always_comb begin
      next_st    = st;
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < gpb_pkg::SYNC_W; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.q[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.q;
endmodule : gpb_sync

// [gpb_rst_share.sv]
// Option capture after reset release and reset/input pin sharing.
`timescale 1ns/1ps
module gpb_rst_share (
   input  wire logic                  clk_sys,
   input  wire logic                  arst_n,
   input  wire logic                  rst_pin_sync,
   input  wire logic                  opt_reset_as_port,
   input  wire gpb_pkg::gpb_clk_sel_t opt_clk_sel,
   output logic                       hold_in_reset,
   output logic                       pin_is_port,
   output gpb_pkg::gpb_clk_sel_t      clk_sel
);
   typedef enum logic {GPB_OPT_WAIT, GPB_OPT_RUN} gpb_opt_state_t;

   typedef struct packed {
      gpb_opt_state_t        state;
      logic                  hold;
      logic                  is_port;
      gpb_pkg::gpb_clk_sel_t clk_sel;
   } gpb_share_state_t;

   localparam gpb_share_state_t SHARE_RST = '{GPB_OPT_WAIT, 1'b1, 1'b0,
                                               gpb_pkg::GPB_CLK_INT_OSC};

   gpb_share_state_t st;
   gpb_share_state_t next_st;

   ////////////////////////////////////////////////////////////////////////////
   // Option is only taken once the pin is seen high, so a low pin holds reset
   always_comb begin
      next_st = st;
      case (st.state)
         GPB_OPT_WAIT: begin
            if (rst_pin_sync) begin
               next_st.state   = GPB_OPT_RUN;
               next_st.hold    = 1'b0;
               next_st.is_port = opt_reset_as_port;
               next_st.clk_sel = opt_clk_sel;
            end
         end
         GPB_OPT_RUN: begin
            // As port input the pin can no longer reset the device
            next_st.hold = !st.is_port && !rst_pin_sync;
         end
         default: begin
            next_st = SHARE_RST;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st <= SHARE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign hold_in_reset = st.hold;
   assign pin_is_port   = st.is_port;
   assign clk_sel       = st.clk_sel;
endmodule : gpb_rst_share

// [gpb_port_bank.sv]
// Port bank top: port registers, pin drivers, pull-ups and alternate functions.
`timescale 1ns/1ps
module gpb_port_bank (
   input  wire logic                  clk_sys,
   input  wire logic                  arst_n,
   input  wire gpb_pkg::gpb_cpu_req_t cpu_req,
   output logic [7:0]                 cpu_rdata,
   input  wire gpb_pkg::gpb_pins_t    pin_in,
   output gpb_pkg::gpb_pins_t         pin_out,
   output gpb_pkg::gpb_pins_t         pin_oe_n,
   output gpb_pkg::gpb_pins_t         pin_pullup_en,
   output logic                       osc_pulldown,
   input  wire logic                  reset_shared_input,
   output logic                       output_only_pin,
   input  wire logic                  opt_reset_as_port,
   input  wire gpb_pkg::gpb_clk_sel_t opt_clk_sel,
   output logic                       hold_in_reset,
   output gpb_pkg::gpb_clk_sel_t      clk_sel,
   output logic [3:0]                 analog_sel_port2,
   output gpb_pkg::gpb_alt_in_t       alt_in,
   input  wire logic                  timer_out_a,
   input  wire logic                  timer_out_b,
   input  wire logic                  serial_tx
);

   ////////////////////////////////////////////////////////////////////////////
   // State of the register file
   typedef struct packed {
      logic [3:0] dir_reg_port0;
      logic [3:0] dir_reg_port2;
      logic [3:0] dir_reg_port3;
      logic [7:0] dir_reg_port4;
      logic [3:0] dir_reg_port12;
      logic [3:0] latch_port0;
      logic [3:0] latch_port2;
      logic [3:0] latch_port3;
      logic [7:0] latch_port4;
      logic [3:0] latch_port12;
      logic       latch_port13;
      logic [3:0] analog_sel_port2;
      logic [3:0] pullup_en_port0;
      logic [3:0] pullup_en_port2;
      logic [3:0] pullup_en_port3;
      logic [7:0] pullup_en_port4;
      logic [3:0] pullup_en_port12;
      logic [7:0] rdata;
   } gpb_bank_state_t;

   // Directions come up as inputs, everything else cleared
   localparam gpb_bank_state_t BANK_RST = '{
      dir_reg_port0:    gpb_pkg::RST_DIR[3:0],
      dir_reg_port2:    gpb_pkg::RST_DIR[3:0],
      dir_reg_port3:    gpb_pkg::RST_DIR[3:0],
      dir_reg_port4:    gpb_pkg::RST_DIR,
      dir_reg_port12:   gpb_pkg::RST_DIR[3:0],
      latch_port0:      gpb_pkg::RST_LATCH[3:0],
      latch_port2:      gpb_pkg::RST_LATCH[3:0],
      latch_port3:      gpb_pkg::RST_LATCH[3:0],
      latch_port4:      gpb_pkg::RST_LATCH,
      latch_port12:     gpb_pkg::RST_LATCH[3:0],
      latch_port13:     gpb_pkg::RST_LATCH[0],
      analog_sel_port2: gpb_pkg::RST_CTRL[3:0],
      pullup_en_port0:  gpb_pkg::RST_CTRL[3:0],
      pullup_en_port2:  gpb_pkg::RST_CTRL[3:0],
      pullup_en_port3:  gpb_pkg::RST_CTRL[3:0],
      pullup_en_port4:  gpb_pkg::RST_CTRL,
      pullup_en_port12: gpb_pkg::RST_CTRL[3:0],
      rdata:            gpb_pkg::RST_CTRL
   };

   gpb_bank_state_t    st;
   gpb_bank_state_t    next_st;
   gpb_pkg::gpb_pins_t pin_s;
   logic               rst_pin_s;
   logic               pin_is_port;
   logic [3:0]         own12;
   logic [7:0]         rd_val;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Byte write replaces all; bit write changes only the addressed bit
   function automatic logic [7:0] wr_merge(
      input logic [7:0]            old,
      input gpb_pkg::gpb_cpu_req_t req
   );
      logic [7:0] res;
      res = req.wdata;
      if (req.bit_op) begin
         res               = old;
         res[req.bit_idx]  = req.wdata[0];
      end
      return res;
   endfunction : wr_merge

   // Inputs read the pin, outputs read the latch
   function automatic logic [7:0] port_read(
      input logic [7:0] latch,
      input logic [7:0] dir,
      input logic [7:0] pin
   );
      return (dir & pin) | (~dir & latch);
   endfunction : port_read

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and reset pin sharing
   gpb_sync u_sync (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .async_in ({reset_shared_input, pin_in}),
      .sync_out ({rst_pin_s, pin_s})
   );

   gpb_rst_share u_share (
      .clk_sys           (clk_sys),
      .arst_n            (arst_n),
      .rst_pin_sync      (rst_pin_s),
      .opt_reset_as_port (opt_reset_as_port),
      .opt_clk_sel       (opt_clk_sel),
      .hold_in_reset     (hold_in_reset),
      .pin_is_port       (pin_is_port),
      .clk_sel           (clk_sel)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Ownership of port 12 bits 1 and 2 by the clock source
   always_comb begin
      case (clk_sel)
         gpb_pkg::GPB_CLK_INT_OSC: own12 = gpb_pkg::OWN_NONE;
         gpb_pkg::GPB_CLK_XTAL:    own12 = gpb_pkg::OWN_XTAL;
         gpb_pkg::GPB_CLK_EXT:     own12 = gpb_pkg::OWN_EXTCLK;
         default:                  own12 = gpb_pkg::OWN_NONE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read value; analog and oscillator-owned bits read as zero
   always_comb begin
      case (cpu_req.addr)
         gpb_pkg::ADDR_LATCH0:
            rd_val = port_read({4'h0, st.latch_port0}, {4'h0, st.dir_reg_port0},
                               {4'h0, pin_s.p0});
         gpb_pkg::ADDR_LATCH2:
            rd_val = port_read({4'h0, st.latch_port2}, {4'h0, st.dir_reg_port2},
                               {4'h0, pin_s.p2}) & {4'h0, ~st.analog_sel_port2};
         gpb_pkg::ADDR_LATCH3:
            rd_val = {3'h0, rst_pin_s,
                      4'(port_read({4'h0, st.latch_port3}, {4'h0, st.dir_reg_port3},
                                   {4'h0, pin_s.p3}))};
         gpb_pkg::ADDR_LATCH4:
            rd_val = port_read(st.latch_port4, st.dir_reg_port4, pin_s.p4);
         gpb_pkg::ADDR_LATCH12:
            rd_val = port_read({4'h0, st.latch_port12}, {4'h0, st.dir_reg_port12},
                               {4'h0, pin_s.p12}) & {4'h0, ~own12};
         gpb_pkg::ADDR_LATCH13: rd_val = {7'h00, st.latch_port13};
         gpb_pkg::ADDR_DIR0:    rd_val = {gpb_pkg::DIR_UNUSED, st.dir_reg_port0};
         gpb_pkg::ADDR_DIR2:    rd_val = {gpb_pkg::DIR_UNUSED, st.dir_reg_port2};
         gpb_pkg::ADDR_DIR3:    rd_val = {gpb_pkg::DIR_UNUSED, st.dir_reg_port3};
         gpb_pkg::ADDR_DIR4:    rd_val = st.dir_reg_port4;
         gpb_pkg::ADDR_DIR12:   rd_val = {gpb_pkg::DIR_UNUSED, st.dir_reg_port12};
         gpb_pkg::ADDR_PU0:     rd_val = {4'h0, st.pullup_en_port0};
         gpb_pkg::ADDR_PU2:     rd_val = {4'h0, st.pullup_en_port2};
         gpb_pkg::ADDR_PU3:     rd_val = {4'h0, st.pullup_en_port3};
         gpb_pkg::ADDR_PU4:     rd_val = st.pullup_en_port4;
         gpb_pkg::ADDR_PULLUP_EN_PORT12:    rd_val = {4'h0, st.pullup_en_port12};
         gpb_pkg::ADDR_ANALOG_SEL_PORT2:    rd_val = {4'h0, st.analog_sel_port2};
         default:               rd_val = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes take effect on the next edge; read data is registered
   always_comb begin
      next_st = st;
      if (cpu_req.rd) begin
         next_st.rdata = rd_val;
      end
      if (cpu_req.wr) begin
         case (cpu_req.addr)
            gpb_pkg::ADDR_DIR0:
               next_st.dir_reg_port0 = 4'(wr_merge({4'h0, st.dir_reg_port0}, cpu_req));
            gpb_pkg::ADDR_DIR2:
               next_st.dir_reg_port2 = 4'(wr_merge({4'h0, st.dir_reg_port2}, cpu_req));
            gpb_pkg::ADDR_DIR3:
               next_st.dir_reg_port3 = 4'(wr_merge({4'h0, st.dir_reg_port3}, cpu_req));
            gpb_pkg::ADDR_DIR4:
               next_st.dir_reg_port4 = wr_merge(st.dir_reg_port4, cpu_req);
            gpb_pkg::ADDR_DIR12:
               next_st.dir_reg_port12 = 4'(wr_merge({4'h0, st.dir_reg_port12}, cpu_req));
            gpb_pkg::ADDR_LATCH0:
               next_st.latch_port0 = 4'(wr_merge({4'h0, st.latch_port0}, cpu_req));
            gpb_pkg::ADDR_LATCH2:
               next_st.latch_port2 = 4'(wr_merge({4'h0, st.latch_port2}, cpu_req));
            gpb_pkg::ADDR_LATCH3:
               // Bit 4 is the input-only pin; writes to it are dropped
               next_st.latch_port3 = 4'(wr_merge({4'h0, st.latch_port3}, cpu_req));
            gpb_pkg::ADDR_LATCH4:
               next_st.latch_port4 = wr_merge(st.latch_port4, cpu_req);
            gpb_pkg::ADDR_LATCH12:
               next_st.latch_port12 = 4'(wr_merge({4'h0, st.latch_port12}, cpu_req));
            gpb_pkg::ADDR_LATCH13:
               // Only bit 0 exists; mask the merged byte down to it
               next_st.latch_port13 = |(wr_merge({7'h00, st.latch_port13}, cpu_req)
                                        & 8'h01);
            gpb_pkg::ADDR_ANALOG_SEL_PORT2:
               next_st.analog_sel_port2 = 4'(wr_merge({4'h0, st.analog_sel_port2}, cpu_req));
            gpb_pkg::ADDR_PU0:
               next_st.pullup_en_port0 = 4'(wr_merge({4'h0, st.pullup_en_port0}, cpu_req));
            gpb_pkg::ADDR_PU2:
               next_st.pullup_en_port2 = 4'(wr_merge({4'h0, st.pullup_en_port2}, cpu_req));
            gpb_pkg::ADDR_PU3:
               next_st.pullup_en_port3 = 4'(wr_merge({4'h0, st.pullup_en_port3}, cpu_req));
            gpb_pkg::ADDR_PU4:
               next_st.pullup_en_port4 = wr_merge(st.pullup_en_port4, cpu_req);
            gpb_pkg::ADDR_PULLUP_EN_PORT12:
               next_st.pullup_en_port12 = 4'(wr_merge({4'h0, st.pullup_en_port12}, cpu_req))
                                          & gpb_pkg::PULLUP_EN_PORT12_MASK;
            default: begin
            end
         endcase
      end
   end

   // Reset gives all-input directions and a low port 13 latch
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st <= BANK_RST;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive: latch value, with timer and serial outputs merged in
   always_comb begin
      pin_out     = '0;
      pin_out.p0  = st.latch_port0;
      pin_out.p2  = st.latch_port2;
      pin_out.p3  = st.latch_port3;
      pin_out.p4  = st.latch_port4;
      pin_out.p12 = st.latch_port12;
      // Latch must be 0 to pass a timer, 1 to pass transmit data
      pin_out.p3[gpb_pkg::P3_TMR_B_BIT] = st.latch_port3[gpb_pkg::P3_TMR_B_BIT]
                                          | timer_out_a;
      pin_out.p4[gpb_pkg::P4_TMRB_BIT]  = st.latch_port4[gpb_pkg::P4_TMRB_BIT]
                                          | timer_out_b;
      pin_out.p4[gpb_pkg::P4_TX_BIT]    = st.latch_port4[gpb_pkg::P4_TX_BIT]
                                          & serial_tx;
   end

   // Enable is low while driving; analog or oscillator use forces it off
   always_comb begin
      pin_oe_n     = '0;
      pin_oe_n.p0  = st.dir_reg_port0;
      pin_oe_n.p2  = st.dir_reg_port2 | st.analog_sel_port2;
      pin_oe_n.p3  = st.dir_reg_port3;
      pin_oe_n.p4  = st.dir_reg_port4;
      pin_oe_n.p12 = st.dir_reg_port12 | own12;
   end

   // Pull-ups only count in input mode on pins the port still owns
   always_comb begin
      pin_pullup_en     = '0;
      pin_pullup_en.p0  = st.pullup_en_port0 & st.dir_reg_port0;
      pin_pullup_en.p2  = st.pullup_en_port2 & st.dir_reg_port2
                          & ~st.analog_sel_port2;
      pin_pullup_en.p3  = st.pullup_en_port3 & st.dir_reg_port3;
      pin_pullup_en.p4  = st.pullup_en_port4 & st.dir_reg_port4;
      pin_pullup_en.p12 = st.pullup_en_port12 & st.dir_reg_port12 & ~own12;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alternate inputs taken from the synchronised pins
   assign alt_in.timer_capture_in_a = pin_s.p3[gpb_pkg::P3_TMR_A_BIT];
   assign alt_in.timer_capture_in_b = pin_s.p3[gpb_pkg::P3_TMR_B_BIT];
   assign alt_in.ext_irq_in[0]      = pin_s.p3[gpb_pkg::P3_TMR_A_BIT];
   assign alt_in.ext_irq_in[2]      = pin_s.p3[gpb_pkg::P3_TMR_B_BIT];
   assign alt_in.ext_irq_in[3]      = pin_s.p4[gpb_pkg::P4_IRQ3_BIT];
   assign alt_in.ext_irq_in[1]      = pin_s.p4[gpb_pkg::P4_TX_BIT];
   assign alt_in.serial_rx          = pin_s.p4[gpb_pkg::P4_RX_BIT];

   // Oscillator pins are pulled down while the device is held in reset
   assign osc_pulldown     = hold_in_reset && !pin_is_port;
   assign output_only_pin  = st.latch_port13;
   assign analog_sel_port2 = st.analog_sel_port2;
   assign cpu_rdata        = st.rdata;
endmodule : gpb_port_bank

// [gpb_chk.sv]
// Checker for the port bank, bound to its top module.
`timescale 1ns/1ps
module gpb_chk (
   input wire logic                  clk_sys,
   input wire logic                  arst_n,
   input wire gpb_pkg::gpb_cpu_req_t cpu_req,
   input wire logic [7:0]            cpu_rdata,
   input wire gpb_pkg::gpb_pins_t    pin_oe_n,
   input wire logic                  output_only_pin,
   input wire logic                  hold_in_reset,
   input wire gpb_pkg::gpb_clk_sel_t clk_sel,
   input wire logic [3:0]            analog_sel_port2
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Full-byte write to one address
   sequence s_wr(a);
      cpu_req.wr && !cpu_req.bit_op && cpu_req.addr == a;
   endsequence
   // Values seen on the first edge after reset is released
   chk_rel_dir: assert property ($rose(arst_n) |-> &pin_oe_n)
      else $error("port not input after reset");
   chk_rel_p13: assert property ($rose(arst_n) |-> !output_only_pin)
      else $error("output pin high after reset");
   chk_rel_hold: assert property ($rose(arst_n) |-> hold_in_reset)
      else $error("reset released before option");
   // Writes and reads land on the next edge
   chk_dir_wr: assert property (s_wr(gpb_pkg::ADDR_DIR0) |=>
      pin_oe_n.p0 == $past(cpu_req.wdata[3:0])) else $error("direction write lost");
   chk_p13_wr: assert property (s_wr(gpb_pkg::ADDR_LATCH13) |=>
      output_only_pin == $past(cpu_req.wdata[0])) else $error("output pin write lost");
   chk_dir_rd: assert property (cpu_req.rd && !cpu_req.wr && cpu_req.addr ==
      gpb_pkg::ADDR_DIR0 |=> cpu_rdata == {4'hF, $past(pin_oe_n.p0)})
      else $error("direction read wrong");
   // Pins owned by the converter or oscillator are never driven
   chk_ana_off: assert property ((pin_oe_n.p2 & analog_sel_port2) == analog_sel_port2)
      else $error("analog pin driven");
   chk_xtal_own: assert property (clk_sel == gpb_pkg::GPB_CLK_XTAL |->
      pin_oe_n.p12[2:1] == 2'b11) else $error("oscillator pin driven");
endmodule : gpb_chk
bind gpb_port_bank gpb_chk i_chk (.clk_sys, .arst_n, .cpu_req, .cpu_rdata, .pin_oe_n,
   .output_only_pin, .hold_in_reset, .clk_sel, .analog_sel_port2);

// [gpb_pin_dev.sv]
// External devices on the port pins: drivers, pull-ups and floating lines.
`timescale 1ns/1ps
module gpb_pin_dev (
   input  wire logic               clk_sys,
   input  wire gpb_pkg::gpb_pins_t pin_out,
   input  wire gpb_pkg::gpb_pins_t pin_oe_n,
   input  wire gpb_pkg::gpb_pins_t pin_pullup_en,
   input  wire gpb_pkg::gpb_pins_t ext_en,
   input  wire gpb_pkg::gpb_pins_t ext_val,
   output gpb_pkg::gpb_pins_t      pin_in
);
   logic [23:0] flt = 24'h55_5555;
   // Floating lines change every cycle so a stale level never passes
   always @(posedge clk_sys) flt <= ~flt;
   // Chip drive first, then device drive, then pull-up, else floating
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                 | (pin_oe_n & ~ext_en & (pin_pullup_en | flt));
endmodule : gpb_pin_dev

// [tb_top.sv]
// Random and corner-case bench for the port bank.
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0, arst_n = 1'b0, p13, pdn, hold;
   gpb_pkg::gpb_cpu_req_t req = '0;
   gpb_pkg::gpb_pins_t pin_in, pin_out, pin_oe_n, pin_pu, ext_en = '0, ext_val = '0;
   gpb_pkg::gpb_clk_sel_t opt_clk = gpb_pkg::GPB_CLK_INT_OSC, clk_sel;
   logic [7:0] rdata;
   logic [3:0] an_sel, d, l, v, u;
   int mismatches = 0, checks = 0, seed = 32'hef14_e06d;
   gpb_pkg::gpb_alt_in_t alt;
   always #5 clk_sys = ~clk_sys;
   gpb_port_bank i_dut (.clk_sys, .arst_n, .cpu_req(req), .cpu_rdata(rdata), .pin_in,
      .pin_out, .pin_oe_n, .pin_pullup_en(pin_pu), .osc_pulldown(pdn),
      .reset_shared_input(1'b1), .output_only_pin(p13), .opt_reset_as_port(1'b0),
      .opt_clk_sel(opt_clk), .hold_in_reset(hold), .clk_sel, .analog_sel_port2(an_sel),
      .alt_in(alt), .timer_out_a(1'b0), .timer_out_b(1'b0), .serial_tx(1'b1));
   gpb_pin_dev i_dev (.clk_sys, .pin_out, .pin_oe_n, .pin_pullup_en(pin_pu), .ext_en,
      .ext_val, .pin_in);
   ////////////////////////////////////////////////////////////////////////////
   // Compare, bus cycle with idle gap, expectations, verdict
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, b, input int i, input logic [15:0] a, x);
      req = '{wr: w, rd: !w, bit_op: b, bit_idx: 3'(i), addr: a, wdata: x[7:0]};
      @(posedge clk_sys);
      #1 req = '0;
      @(posedge clk_sys);
      #1;
   endtask : bus
   function automatic logic [7:0] exp_port(input logic [3:0] dr, lt, pn);
      return {4'h0, (~dr & lt) | (dr & pn)};
   endfunction : exp_port
   function automatic logic [7:0] own(input int k);
      return (k == 1) ? 8'h06 : (k == 2) ? 8'h02 : 8'h00;
   endfunction : own
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////////////////
   // One reset per clock option; the budget covers all three passes more than twenty times over
   initial begin
      #100000 mismatches++;
      end_of_test();
   end
   initial begin
      for (int k = 0; k < 3; k++) begin
         #1 arst_n = 1'b0;
         opt_clk = gpb_pkg::gpb_clk_sel_t'(k);
         repeat (16) @(posedge clk_sys);
         chk("p13_rst", 8'h00, {7'h0, p13});
         chk("pdn_rst", 8'h01, {7'h0, pdn});
         #1 arst_n = 1'b1;
         repeat (12) @(posedge clk_sys);
         #1 chk("hold", 8'h00, {7'h0, hold});
         chk("clk_sel", k[7:0], {6'h0, clk_sel});
         bus(0, 0, 0, gpb_pkg::ADDR_DIR0, 0);
         chk("dir0_rst", 8'hFF, rdata);
         bus(1, 0, 0, gpb_pkg::ADDR_DIR12, 0);
         chk("own12", own(k), {4'h0, pin_oe_n.p12});
         bus(1, 1, k + 5, gpb_pkg::ADDR_DIR4, 0);
         bus(0, 0, 0, gpb_pkg::ADDR_DIR4, 0);
         chk("dir4_bit", ~(8'h01 << (k + 5)), rdata);
         bus(1, 0, 0, gpb_pkg::ADDR_LATCH13, 8'hFF);
         chk("p13", 8'h01, {7'h0, p13});
         bus(1, 0, 0, gpb_pkg::ADDR_ANALOG_SEL_PORT2, 8'h05);
         bus(1, 0, 0, gpb_pkg::ADDR_DIR2, 0);
         chk("ana_oe", 8'h05, {4'h0, pin_oe_n.p2});
         chk("ana_sel", 8'h05, {4'h0, an_sel});
         bus(1, 0, 0, gpb_pkg::ADDR_PULLUP_EN_PORT12, 8'hFF);
         bus(0, 0, 0, gpb_pkg::ADDR_PULLUP_EN_PORT12, 0);
         chk("pullup_en_port12", 8'h09, rdata);
         // Random direction, latch, pull-up and far-side levels on port 0
         repeat (8) begin
            {d, l, v, u} = 16'($random(seed));
            ext_en.p0 = d;
            ext_val.p0 = v;
            ext_en.p3 = 4'hF;
            ext_val.p3 = v;
            bus(1, 0, 0, gpb_pkg::ADDR_PU0, {4'h0, u});
            bus(1, 0, 0, gpb_pkg::ADDR_LATCH0, {4'h0, l});
            bus(1, 0, 0, gpb_pkg::ADDR_DIR0, {4'h0, d});
            chk("pu0", {4'h0, u & d}, {4'h0, pin_pu.p0});
            repeat (5) @(posedge clk_sys);
            #1 bus(0, 0, 0, gpb_pkg::ADDR_LATCH0, 0);
            chk("port0", exp_port(d, l, v), rdata);
            chk("alt_cap", {7'h0, v[0]}, {7'h0, alt.timer_capture_in_a});
         end
      end
      end_of_test();
   end
endmodule : tb_top
